// >>> hdl/ldr_pkg.sv
// Package for the LED duty ramp and off-delay controller.
// Assumes a 100 MHz clock and a classic Wishbone register port.
package ldr_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] PULSE_ONE_OFS = 8'h90;
  localparam logic [7:0] PULSE_TWO_OFS = 8'h91;
  localparam logic [7:0] BREATHE_OFS = 8'h92;
  localparam logic [7:0] DIRECT_OFS = 8'h93;
  localparam logic [7:0] RAMP_OFS = 8'h94;
  localparam logic [7:0] OFFDLY_OFS = 8'h95;
  localparam logic [7:0] CTRL_OFS = 8'h98;
  localparam logic [7:0] STATUS_OFS = 8'h99;
  localparam logic [7:0] BREATHE_PER_OFS = 8'h9a;
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] LIMITS_RST = 8'hf0;
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam logic [7:0] OFFDLY_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BREATHE_PER_RST = 8'h5d;
  localparam int UPPER_LSB = 4;
  localparam int RISE_LSB = 3;
  localparam int FALL_LSB = 0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int PERIOD_UNIT_MS = 32;
  localparam logic [6:0] PWM_TOP = 7'h63;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RISE = 3'b001, ST_HOLD = 3'b011,
    ST_DELAY = 3'b010, ST_FALL = 3'b110
  } ldr_state_t;
  typedef enum logic [1:0] {
    MD_PULSE1 = 2'h0, MD_PULSE2 = 2'h1, MD_BREATHE = 2'h2, MD_DIRECT = 2'h3
  } ldr_mode_t;
endpackage

// >>> hdl/ldr_ctrl.sv
// LED duty ramp controller: limits, ramp times, off delay and PWM output.
// Assumes a synchronous Wishbone master and a single 100 MHz clock.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ldr_ctrl #(
  parameter int TICK_DIV = ldr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // LED side
  input wire logic activate_i,
  output logic led_o
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [6:0] upper_pct(input logic [3:0] c);
    logic [6:0] t [16];
    t = '{7'd7, 7'd9, 7'd11, 7'd14, 7'd17, 7'd20, 7'd23, 7'd26,
          7'd30, 7'd35, 7'd40, 7'd46, 7'd53, 7'd63, 7'd77, 7'd100};
    return t[c];
  endfunction
  function automatic logic [6:0] lower_pct(input logic [3:0] c);
    return (c == 4'h0) ? 7'd0 : upper_pct(c - 4'h1);
  endfunction
  function automatic logic [12:0] ramp_ms(input logic [2:0] c);
    return (c == 3'h7) ? 13'd2000 : 13'(c) * 13'd250;
  endfunction
  function automatic logic [12:0] delay_ms(input logic [2:0] c);
    return (c <= 3'h4) ? 13'(c) * 13'd500 : 13'(c - 3'h2) * 13'd1000;
  endfunction
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] lim_q [4];
  logic [7:0] lim_d [4];
  logic [7:0] ramp_q, ramp_d, offdly_q, offdly_d, ctrl_q, ctrl_d, per_q, per_d;
  logic [31:0] dat_d;
  logic ack_d, wr;
  ldr_pkg::ldr_state_t st_q, st_d;
  logic [6:0] duty_q, duty_d;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  always_comb begin
    lim_d = lim_q;
    ramp_d = ramp_q;
    offdly_d = offdly_q;
    ctrl_d = ctrl_q;
    per_d = per_q;
    ack_d = cyc_i && stb_i && !ack_o;
    dat_d = 32'h0;
    if (wr) begin
      unique case (adr_i)
        ldr_pkg::PULSE_ONE_OFS: lim_d[0] = dat_i[7:0];
        ldr_pkg::PULSE_TWO_OFS: lim_d[1] = dat_i[7:0];
        ldr_pkg::BREATHE_OFS: lim_d[2] = dat_i[7:0];
        ldr_pkg::DIRECT_OFS: lim_d[3] = dat_i[7:0];
        ldr_pkg::RAMP_OFS: ramp_d = {2'h0, dat_i[5:0]};
        ldr_pkg::OFFDLY_OFS: offdly_d = {5'h0, dat_i[2:0]};
        ldr_pkg::CTRL_OFS: ctrl_d = {6'h0, dat_i[1:0]};
        ldr_pkg::BREATHE_PER_OFS: per_d = {1'b0, dat_i[6:0]};
        default: ;
      endcase
    end
    if (cyc_i && stb_i && !we_i) begin
      unique case (adr_i)
        ldr_pkg::PULSE_ONE_OFS: dat_d = {24'h0, lim_q[0]};
        ldr_pkg::PULSE_TWO_OFS: dat_d = {24'h0, lim_q[1]};
        ldr_pkg::BREATHE_OFS: dat_d = {24'h0, lim_q[2]};
        ldr_pkg::DIRECT_OFS: dat_d = {24'h0, lim_q[3]};
        ldr_pkg::RAMP_OFS: dat_d = {24'h0, ramp_q};
        ldr_pkg::OFFDLY_OFS: dat_d = {24'h0, offdly_q};
        ldr_pkg::CTRL_OFS: dat_d = {24'h0, ctrl_q};
        ldr_pkg::STATUS_OFS: dat_d = {22'h0, st_q, duty_q};
        ldr_pkg::BREATHE_PER_OFS: dat_d = {24'h0, per_q};
        default: dat_d = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lim_q <= '{default: ldr_pkg::LIMITS_RST};
      ramp_q <= ldr_pkg::RAMP_RST;
      offdly_q <= ldr_pkg::OFFDLY_RST;
      ctrl_q <= ldr_pkg::CTRL_RST;
      per_q <= ldr_pkg::BREATHE_PER_RST;
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      lim_q <= lim_d;
      ramp_q <= ramp_d;
      offdly_q <= offdly_d;
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      ack_o <= ack_d;
      dat_o <= dat_d;
    end
  end
  // ----------------------------------------
  // Millisecond tick and PWM counter
  // ----------------------------------------
  // The tick divider keeps every slower rate a one-cycle enable.
  logic [31:0] div_q, div_d;
  logic tick;
  logic [6:0] pwm_q, pwm_d;
  assign tick = (div_q == 32'(TICK_DIV - 1));
  always_comb begin
    div_d = tick ? 32'h0 : div_q + 32'h1;
    pwm_d = (pwm_q == ldr_pkg::PWM_TOP) ? 7'h0 : pwm_q + 7'h1;
  end
  // ----------------------------------------
  // Ramp sequencer
  // ----------------------------------------
  logic [7:0] snap_q, snap_d;
  logic act_q, act_d;
  logic [15:0] tmr_q, tmr_d;
  logic [6:0] hi, lo, span;
  logic [15:0] step_ms;
  logic [1:0] mode;
  logic direct;
  assign mode = ctrl_q[1:0];
  assign direct = (mode == 2'(ldr_pkg::MD_DIRECT));
  always_comb begin
    // Direct limits live; others use the activation snapshot.
    hi = upper_pct(direct ? lim_q[3][7:4] : snap_q[7:4]);
    lo = lower_pct(direct ? lim_q[3][3:0] : snap_q[3:0]);
    span = (hi > lo) ? hi - lo : 7'h1;
    // Breathe: half the period per ramp, zero counts as one unit.
    step_ms = 16'(((per_q[6:0] == 7'h0) ? 8'd1 : {1'b0, per_q[6:0]}) * 16'(ldr_pkg::PERIOD_UNIT_MS)
              / 16'(2 * span));
  end
  always_comb begin
    st_d = st_q;
    duty_d = duty_q;
    tmr_d = tmr_q;
    snap_d = snap_q;
    act_d = activate_i;
    if (activate_i && !act_q) begin
      snap_d = lim_q[mode];
    end
    unique case (st_q)
      ldr_pkg::ST_IDLE: begin
        duty_d = lo;
        if (activate_i) begin
          st_d = ldr_pkg::ST_RISE;
          tmr_d = 16'h0;
        end
      end
      ldr_pkg::ST_RISE: begin
        // Rise at the pace of the rise time in direct mode, else over half the breathe period.
        if (duty_q >= hi) begin
          duty_d = hi;
          st_d = direct ? ldr_pkg::ST_HOLD : ldr_pkg::ST_FALL;
        end else if (direct && ramp_q[5:3] == 3'h0) begin
          duty_d = hi;
        end else if (tick) begin
          tmr_d = tmr_q + 16'h1;
          if (tmr_q + 16'h1 >= (direct ? 16'(ramp_ms(ramp_q[5:3])) / 16'(span) : step_ms)) begin
            tmr_d = 16'h0;
            duty_d = duty_q + 7'h1;
          end
        end
      end
      ldr_pkg::ST_HOLD: begin
        duty_d = hi;
        if (!activate_i) begin
          st_d = ldr_pkg::ST_DELAY;
          tmr_d = 16'h0;
        end
      end
      ldr_pkg::ST_DELAY: begin
        duty_d = hi;
        if (activate_i) begin
          st_d = ldr_pkg::ST_HOLD;
        end else if (tmr_q >= 16'(delay_ms(offdly_q[2:0]))) begin
          st_d = ldr_pkg::ST_FALL;
          tmr_d = 16'h0;
        end else if (tick) begin
          tmr_d = tmr_q + 16'h1;
        end
      end
      ldr_pkg::ST_FALL: begin
        // Fall at the pace of the fall time in direct mode, else over half the breathe period.
        if (duty_q <= lo) begin
          duty_d = lo;
          st_d = (activate_i && !direct) ? ldr_pkg::ST_RISE : ldr_pkg::ST_IDLE;
        end else if (direct && ramp_q[2:0] == 3'h0) begin
          duty_d = lo;
        end else if (tick) begin
          tmr_d = tmr_q + 16'h1;
          if (tmr_q + 16'h1 >= (direct ? 16'(ramp_ms(ramp_q[2:0])) / 16'(span) : step_ms)) begin
            tmr_d = 16'h0;
            duty_d = duty_q - 7'h1;
          end
        end
      end
      default: st_d = ldr_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_q <= 32'h0;
      pwm_q <= 7'h0;
      st_q <= ldr_pkg::ST_IDLE;
      duty_q <= 7'h0;
      tmr_q <= 16'h0;
      snap_q <= ldr_pkg::LIMITS_RST;
      act_q <= 1'b0;
      led_o <= 1'b0;
    end else begin
      div_q <= div_d;
      pwm_q <= pwm_d;
      st_q <= st_d;
      duty_q <= duty_d;
      tmr_q <= tmr_d;
      snap_q <= snap_d;
      act_q <= act_d;
      // On while the counter is below the duty.
      led_o <= (pwm_q < duty_q);
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ack_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  led_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
    duty_q == 7'h0 |=> !led_o) else $error("led on at zero duty");
  idle_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_IDLE |=> duty_q == $past(lo)) else $error("idle duty not lower");
  hold_hi_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_HOLD && activate_i |=> duty_q == $past(hi))
    else $error("hold duty not upper");
  release_dly_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_HOLD && !activate_i |=> st_q == ldr_pkg::ST_DELAY)
    else $error("release did not start delay");
  rise_fast_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_RISE && direct && ramp_q[5:3] == 3'h0 |=> ##[0:2] duty_q == hi)
    else $error("zero rise not immediate");
  fall_fast_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_FALL && direct && ramp_q[2:0] == 3'h0 |=> ##[0:2] duty_q == lo)
    else $error("zero fall not immediate");
  zero_dly_a: assert property (@(posedge clock_i) disable iff (rst_i)
    st_q == ldr_pkg::ST_DELAY && offdly_q[2:0] == 3'h0 && !activate_i
    |=> st_q == ldr_pkg::ST_FALL) else $error("zero delay not immediate");
  duty_max_a: assert property (@(posedge clock_i) disable iff (rst_i)
    duty_q <= 7'd100) else $error("duty above full");
  rise_c: cover property (@(posedge clock_i) st_q == ldr_pkg::ST_RISE);
  delay_c: cover property (@(posedge clock_i) st_q == ldr_pkg::ST_DELAY);
  fall_c: cover property (@(posedge clock_i) st_q == ldr_pkg::ST_FALL);
endmodule

// >>> test/ldr_led_model.sv
// LED load model: reports the on share of the last PWM period.
// Assumes the controller's 100-cycle PWM period.
`timescale 1ns/1ps
module ldr_led_model (
  // Clock
  input wire logic clock_i,
  // LED drive
  input wire logic led_i,
  output logic [6:0] on_pct_o
);
  logic [99:0] hist_q;
  always_ff @(posedge clock_i) begin
    hist_q <= {hist_q[98:0], led_i};
  end
  assign on_pct_o = 7'($countones(hist_q));
endmodule

// >>> test/ldr_ctrl_tb.sv
// Bench for the LED duty ramp controller.
// Assumes one-cycle ack and a 1 ms tick of 10 cycles.
`timescale 1ns/1ps
module ldr_ctrl_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic activate_i = 1'b0;
  logic led_o;
  logic [6:0] on_pct;
  logic [31:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  logic [6:0] maxp [16] = '{7'h07, 7'h09, 7'h0b, 7'h0e, 7'h11, 7'h14, 7'h17, 7'h1a,
    7'h1e, 7'h23, 7'h28, 7'h2e, 7'h35, 7'h3f, 7'h4d, 7'h64};
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  ldr_ctrl #(.TICK_DIV(10)) dut (.clock_i(clock_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .activate_i(activate_i), .led_o(led_o));
  ldr_led_model led (.clock_i(clock_i), .led_i(led_o), .on_pct_o(on_pct));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read data is taken in the ack cycle; the request drops at the next edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clock_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      wrap_up();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic stat(input logic [2:0] s);
    wb(1'b0, ldr_pkg::STATUS_OFS, 8'h00);
    chk({29'h0, rd[9:7]}, {29'h0, s});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      if (i != 2) begin
        wb(1'b0, 8'(8'h90 + i), 8'h00);
        chk(rd, (i < 4) ? 32'hf0 : 32'h0);
      end
    end
    wb(1'b1, ldr_pkg::PULSE_TWO_OFS, 8'h5a);
    wb(1'b0, ldr_pkg::PULSE_TWO_OFS, 8'h00);
    chk(rd, 32'h5a);
    wb(1'b0, 8'ha0, 8'h00);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_decode;
    wb(1'b1, ldr_pkg::CTRL_OFS, 8'h03);
    activate_i <= 1'b1;
    for (int u = 0; u < 16; u++) begin
      wb(1'b1, ldr_pkg::DIRECT_OFS, {4'(u), 4'h0});
      idle(20);
      wb(1'b0, ldr_pkg::STATUS_OFS, 8'h00);
      chk({25'h0, rd[6:0]}, {25'h0, maxp[u]});
    end
    wb(1'b1, ldr_pkg::DIRECT_OFS, 8'h90);
    idle(150);
    chk({25'h0, on_pct}, 32'd35);
    activate_i <= 1'b0;
    idle(20);
    for (int l = 0; l < 16; l++) begin
      wb(1'b1, ldr_pkg::DIRECT_OFS, {4'hf, 4'(l)});
      idle(20);
      wb(1'b0, ldr_pkg::STATUS_OFS, 8'h00);
      chk({25'h0, rd[6:0]}, (l == 0) ? 32'h0 : {25'h0, maxp[l - 1]});
    end
    $display("test decode done");
  endtask
  // Rise and fall of 1 s over 100 steps, off delay 0.5 s, all at 10 cycles a ms.
  task automatic t_direct;
    wb(1'b1, ldr_pkg::DIRECT_OFS, 8'hf0);
    // Host keeps rise equal to the wanted fall.
    wb(1'b1, ldr_pkg::RAMP_OFS, 8'h24);
    wb(1'b1, ldr_pkg::OFFDLY_OFS, 8'h01);
    activate_i <= 1'b1;
    idle(8000);
    stat(ldr_pkg::ST_RISE);
    idle(3000);
    stat(ldr_pkg::ST_HOLD);
    chk({25'h0, rd[6:0]}, 32'd100);
    activate_i <= 1'b0;
    idle(4000);
    stat(ldr_pkg::ST_DELAY);
    chk({25'h0, rd[6:0]}, 32'd100);
    idle(1500);
    stat(ldr_pkg::ST_FALL);
    idle(10000);
    stat(ldr_pkg::ST_IDLE);
    chk({25'h0, rd[6:0]}, 32'h0);
    $display("test direct done");
  endtask
  task automatic t_breathe;
    logic [6:0] top;
    top = 7'h00;
    wb(1'b1, ldr_pkg::CTRL_OFS, 8'h02);
    wb(1'b1, ldr_pkg::BREATHE_PER_OFS, 8'h01);
    wb(1'b1, ldr_pkg::BREATHE_OFS, 8'h30);
    activate_i <= 1'b1;
    wb(1'b1, ldr_pkg::BREATHE_OFS, 8'hf0);
    repeat (300) begin
      wb(1'b0, ldr_pkg::STATUS_OFS, 8'h00);
      top = (rd[6:0] > top) ? rd[6:0] : top;
    end
    chk({25'h0, top}, 32'd14);
    activate_i <= 1'b0;
    idle(20);
    activate_i <= 1'b1;
    repeat (300) begin
      wb(1'b0, ldr_pkg::STATUS_OFS, 8'h00);
      top = (rd[6:0] > top) ? rd[6:0] : top;
    end
    chk({31'h0, top > 7'd14}, 32'h1);
    $display("test breathe done");
  endtask
  initial begin
    idle(12);
    rst_i <= 1'b0;
    t_reset();
    t_decode();
    t_direct();
    t_breathe();
    wrap_up();
  end
endmodule
